// [src/udpil_consts.svh]
// Offsets, field positions, reset values and counts of the serial data-port and event logic.
// Definitions only; included by every file that decodes registers.
`ifndef UDPIL_CONSTS_SVH
`define UDPIL_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define UDPIL_IDX_DATA 4'h0
`define UDPIL_IDX_IER 4'h1
`define UDPIL_IDX_EIR 4'h2
`define UDPIL_IDX_LSR 4'h5
`define UDPIL_IDX_MSR 4'h6
`define UDPIL_IDX_EXT 4'h8

// ==========================================================
// Queue control fields
`define UDPIL_QC_EN 0
`define UDPIL_QC_RXRST 1
`define UDPIL_QC_TXRST 2
`define UDPIL_QC_TXTH_LO 4
`define UDPIL_QC_RXTH_LO 6
// Receive thresholds for codes 00..11
`define UDPIL_RXTH_0 1
`define UDPIL_RXTH_1 4
`define UDPIL_RXTH_2 8
`define UDPIL_RXTH_3 14
// Transmit thresholds for codes 00..11
`define UDPIL_TXTH_0 1
`define UDPIL_TXTH_1 3
`define UDPIL_TXTH_2 9
`define UDPIL_TXTH_3 13

// ==========================================================
// Interrupt enable fields and masks
`define UDPIL_IE_RX 0
`define UDPIL_IE_TX 1
`define UDPIL_IE_LINE 2
`define UDPIL_IE_MODEM 3
`define UDPIL_IER_LEGACY_MASK 8'h0F
`define UDPIL_IER_EXT_MASK 8'h2F
`define UDPIL_IER_RESET 8'h00

// ==========================================================
// Legacy identification codes
`define UDPIL_ID_NONE 4'h1
`define UDPIL_ID_LINE 4'h6
`define UDPIL_ID_RXLVL 4'h4
`define UDPIL_ID_RXTO 4'hC
`define UDPIL_ID_TXLOW 4'h2
`define UDPIL_ID_MODEM 4'h0

// ==========================================================
// Timing and bus answers
`define UDPIL_TIMEOUT_CHARS 3'h4
`define UDPIL_RESP_OKAY 2'h0
`define UDPIL_RESP_SLVERR 2'h2

`endif

// [src/udpil_pkg.sv]
// Types shared by the serial data-port and event logic.
// No assumptions on surroundings.
package udpil_pkg;
  typedef logic [7:0] udpil_byte_t;
  typedef logic [1:0] udpil_resp_t;
  typedef logic [5:0] udpil_addr_t;
endpackage

// [src/udpil_sync.sv]
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs change slowly compared with mclk.
`timescale 1ns/1ns
module udpil_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// [src/udpil_queue.sv]
// Word queue of WIDTH bits with level count; head word is read without popping.
// Assumes the owner never pushes when full nor pops when empty.
`timescale 1ns/1ns
module udpil_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  // State
  output logic [WIDTH-1:0] head,
  output logic [CW-1:0] count,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;

  assign head = mem[rdPtr_reg];
  assign empty = (count == '0);
  assign full = (count == CW'(DEPTH));

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= pushData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count <= '0;
    end else if (clear) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// [src/udpil_top.sv]
// Data ports, interrupt enables and event identification of a serial controller.
// Assumes receiver, transmitter and character tick on mclk; modem pins are asynchronous.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "udpil_consts.svh"
module udpil_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write
  input wire udpil_pkg::udpil_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output udpil_pkg::udpil_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire udpil_pkg::udpil_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output udpil_pkg::udpil_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // Receiver side
  input wire logic rxValid,
  input wire udpil_pkg::udpil_byte_t rxData,
  input wire logic rxParityErr,
  input wire logic rxFrameErr,
  input wire logic rxBreak,
  input wire logic charTick,
  // Transmitter side
  output logic txValid,
  output udpil_pkg::udpil_byte_t txData,
  input wire logic txReady,
  input wire logic txIdle,
  // Modem pins, active low
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic dcdN,
  input wire logic riN,
  // Interrupt
  output logic irq
);
  import udpil_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;

  // ==========================================================
  // State
  logic fifoEn_reg;
  logic [1:0] rxTh_reg;
  logic [1:0] txTh_reg;
  logic extMode_reg;
  udpil_byte_t ier_reg;
  logic [3:0] lsrErr_reg;
  logic [3:0] msrDelta_reg;
  logic [3:0] modemPrev_reg;
  logic timeout_reg;
  logic [2:0] idle_reg;
  logic txLow_reg;
  logic txEmptyPrev_reg;

  // ==========================================================
  // Bus decode
  wire [3:0] wrIdx = awaddr[5:2];
  wire [3:0] rdIdx = araddr[5:2];
  wire wrFire = awvalid & awready & wvalid & wready;
  wire rdFire = arvalid & arready;
  wire wrLow = wrFire & wstrb[0];
  wire wrData = wrLow & (wrIdx == `UDPIL_IDX_DATA);
  wire wrIer = wrLow & (wrIdx == `UDPIL_IDX_IER);
  wire wrQc = wrLow & (wrIdx == `UDPIL_IDX_EIR);
  wire wrExt = wrLow & (wrIdx == `UDPIL_IDX_EXT);
  wire rdData = rdFire & (rdIdx == `UDPIL_IDX_DATA);
  wire rdEir = rdFire & (rdIdx == `UDPIL_IDX_EIR);
  wire rdLsr = rdFire & (rdIdx == `UDPIL_IDX_LSR);
  wire rdMsr = rdFire & (rdIdx == `UDPIL_IDX_MSR);
  wire wrMapped = (wrIdx <= `UDPIL_IDX_MSR) && (wrIdx != 4'h3) && (wrIdx != 4'h4)
                  || (wrIdx == `UDPIL_IDX_EXT);
  wire rdMapped = (rdIdx <= `UDPIL_IDX_MSR) && (rdIdx != 4'h3) && (rdIdx != 4'h4)
                  || (rdIdx == `UDPIL_IDX_EXT);

  // ==========================================================
  // Queues
  logic [10:0] rxHead;
  logic [CW-1:0] rxCount;
  logic rxEmpty;
  logic rxFull;
  udpil_byte_t txHead;
  logic [CW-1:0] txCount;
  logic txEmpty;
  logic txFull;

  wire qcEnNew = wdata[`UDPIL_QC_EN];
  // Toggling the enable flushes both queues
  wire qcFlip = wrQc & (qcEnNew != fifoEn_reg);
  wire rxClear = qcFlip | (wrQc & wdata[`UDPIL_QC_RXRST]);
  wire txClear = qcFlip | (wrQc & wdata[`UDPIL_QC_TXRST]);
  // Without queues a single holding byte is all there is
  wire rxRoom = fifoEn_reg ? !rxFull : rxEmpty;
  wire txRoom = fifoEn_reg ? !txFull : txEmpty;
  wire rxPush = rxValid & rxRoom;
  wire rxOverrun = rxValid & !rxRoom;
  wire rxPop = rdData & !rxEmpty;
  wire txPush = wrData & txRoom;
  wire txPop = !txEmpty & (!txValid | txReady);

  udpil_queue #(.WIDTH(11), .DEPTH(DEPTH)) rxQueue (
    .mclk(mclk),
    .rst(rst),
    .clear(rxClear),
    .push(rxPush),
    .pushData({rxBreak, rxFrameErr, rxParityErr, rxData}),
    .pop(rxPop),
    .head(rxHead),
    .count(rxCount),
    .empty(rxEmpty),
    .full(rxFull)
  );

  udpil_queue #(.WIDTH(8), .DEPTH(DEPTH)) txQueue (
    .mclk(mclk),
    .rst(rst),
    .clear(txClear),
    .push(txPush),
    .pushData(wdata[7:0]),
    .pop(txPop),
    .head(txHead),
    .count(txCount),
    .empty(txEmpty),
    .full(txFull)
  );

  // ==========================================================
  // Modem pins
  logic [3:0] modemSync;
  udpil_sync #(.WIDTH(4), .INIT(4'hF)) modemSyncer (
    .mclk(mclk),
    .rst(rst),
    .d({dcdN, riN, dsrN, ctsN}),
    .q(modemSync)
  );
  wire [3:0] modemChg = modemSync ^ modemPrev_reg;
  // Ring counts only its trailing edge
  wire [3:0] modemSet = {modemChg[3], modemChg[2] & modemSync[2], modemChg[1:0]};

  // ==========================================================
  // Events
  wire [CW-1:0] rxThVal = (rxTh_reg == 2'h0) ? CW'(`UDPIL_RXTH_0) :
                          (rxTh_reg == 2'h1) ? CW'(`UDPIL_RXTH_1) :
                          (rxTh_reg == 2'h2) ? CW'(`UDPIL_RXTH_2) : CW'(`UDPIL_RXTH_3);
  wire [CW-1:0] txThVal = (txTh_reg == 2'h0) ? CW'(`UDPIL_TXTH_0) :
                          (txTh_reg == 2'h1) ? CW'(`UDPIL_TXTH_1) :
                          (txTh_reg == 2'h2) ? CW'(`UDPIL_TXTH_2) : CW'(`UDPIL_TXTH_3);
  wire rxLevel = fifoEn_reg ? (rxCount >= rxThVal) : !rxEmpty;
  wire toSet = fifoEn_reg & !rxEmpty & charTick
               & (idle_reg == `UDPIL_TIMEOUT_CHARS - 3'h1);
  wire txLowLevel = fifoEn_reg ? (txCount < txThVal) : txEmpty;
  wire txAllEmpty = txEmpty & !txValid & txIdle;
  wire lineEvt = |lsrErr_reg;
  wire modemEvt = |msrDelta_reg;
  wire [3:0] errSet = {rxPush & rxBreak, rxPush & rxFrameErr, rxPush & rxParityErr, rxOverrun};

  // ==========================================================
  // Identification
  wire pendLine = lineEvt & ier_reg[`UDPIL_IE_LINE];
  wire pendRx = rxLevel & ier_reg[`UDPIL_IE_RX];
  wire pendTo = timeout_reg & ier_reg[`UDPIL_IE_RX];
  wire pendTx = txLow_reg & ier_reg[`UDPIL_IE_TX];
  wire pendMs = modemEvt & ier_reg[`UDPIL_IE_MODEM];
  wire [3:0] legacyCode = pendLine ? `UDPIL_ID_LINE :
                          pendRx ? `UDPIL_ID_RXLVL :
                          (pendTo & fifoEn_reg) ? `UDPIL_ID_RXTO :
                          pendTx ? `UDPIL_ID_TXLOW :
                          pendMs ? `UDPIL_ID_MODEM : `UDPIL_ID_NONE;
  wire [7:0] legacyEir = {fifoEn_reg, fifoEn_reg, 2'h0, legacyCode};
  wire [7:0] extEir = {2'h0, txAllEmpty, 1'b0, modemEvt, lineEvt, txLowLevel,
                       rxLevel | timeout_reg};
  wire [7:0] eirVal = extMode_reg ? extEir : legacyEir;
  wire txLowTop = !extMode_reg & (legacyCode == `UDPIL_ID_TXLOW);
  wire irqNext = extMode_reg ? |(extEir & ier_reg) : !legacyCode[0];
  wire [7:0] ierMask = extMode_reg ? `UDPIL_IER_EXT_MASK : `UDPIL_IER_LEGACY_MASK;

  // ==========================================================
  // Read data
  wire [7:0] lsrVal = {1'b0, txAllEmpty, txEmpty, lsrErr_reg, !rxEmpty};
  wire [7:0] msrVal = {~modemSync, msrDelta_reg};
  wire [7:0] rdByte = (rdIdx == `UDPIL_IDX_DATA) ? rxHead[7:0] :
                      (rdIdx == `UDPIL_IDX_IER) ? ier_reg :
                      (rdIdx == `UDPIL_IDX_EIR) ? eirVal :
                      (rdIdx == `UDPIL_IDX_LSR) ? lsrVal :
                      (rdIdx == `UDPIL_IDX_MSR) ? msrVal :
                      (rdIdx == `UDPIL_IDX_EXT) ? {7'h0, extMode_reg} : 8'h00;

  // ==========================================================
  // Bus handshakes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `UDPIL_RESP_OKAY;
    end else begin
      // Both channels are taken together so a write is never half done
      awready <= awvalid & wvalid & !awready & !bvalid;
      wready <= awvalid & wvalid & !awready & !bvalid;
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= wrMapped ? `UDPIL_RESP_OKAY : `UDPIL_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `UDPIL_RESP_OKAY;
    end else begin
      arready <= arvalid & !arready & !rvalid;
      if (rdFire) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rdByte};
        rresp <= rdMapped ? `UDPIL_RESP_OKAY : `UDPIL_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fifoEn_reg <= 1'b0;
      rxTh_reg <= 2'h0;
      txTh_reg <= 2'h0;
      extMode_reg <= 1'b0;
      ier_reg <= `UDPIL_IER_RESET;
    end else begin
      if (wrQc) begin
        fifoEn_reg <= qcEnNew;
        rxTh_reg <= wdata[`UDPIL_QC_RXTH_LO +: 2];
        txTh_reg <= wdata[`UDPIL_QC_TXTH_LO +: 2];
      end
      if (wrExt) begin
        extMode_reg <= wdata[0];
      end
      if (wrIer) begin
        ier_reg <= wdata[7:0] & ierMask;
      end else if (!extMode_reg) begin
        ier_reg <= ier_reg & `UDPIL_IER_LEGACY_MASK;
      end
    end
  end

  // ==========================================================
  // Event flags; a set always beats a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lsrErr_reg <= 4'h0;
      msrDelta_reg <= 4'h0;
      modemPrev_reg <= 4'hF;
      timeout_reg <= 1'b0;
      idle_reg <= 3'h0;
      txLow_reg <= 1'b0;
      txEmptyPrev_reg <= 1'b1;
    end else begin
      lsrErr_reg <= errSet | (lsrErr_reg & {4{!rdLsr}});
      msrDelta_reg <= modemSet | (msrDelta_reg & {4{!rdMsr}});
      modemPrev_reg <= modemSync;
      if (rxPush | rxPop | rxEmpty | !fifoEn_reg) begin
        idle_reg <= 3'h0;
      end else if (charTick && idle_reg != `UDPIL_TIMEOUT_CHARS) begin
        idle_reg <= idle_reg + 3'h1;
      end
      timeout_reg <= toSet | (timeout_reg & !rxPop & !rxClear);
      txEmptyPrev_reg <= txEmpty;
      txLow_reg <= (txEmpty & !txEmptyPrev_reg)
                   | (wrIer & wdata[`UDPIL_IE_TX] & txEmpty)
                   | (txLow_reg & !wrData & !(rdEir & txLowTop));
    end
  end

  // ==========================================================
  // Transmit output stage and interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      irq <= 1'b0;
    end else begin
      if (txClear) begin
        txValid <= 1'b0;
      end else if (txPop) begin
        txValid <= 1'b1;
        txData <= txHead;
      end else if (txReady) begin
        txValid <= 1'b0;
      end
      irq <= irqNext;
    end
  end
endmodule

// [dv/udpil_monitor.sv]
// Checker for the data-port and event logic, watching its top ports only.
// Assumes the mode bits change only through accepted bus writes.
`timescale 1ns/1ns
`include "udpil_consts.svh"
module udpil_monitor #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire udpil_pkg::udpil_addr_t awaddr,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wready,
  input wire udpil_pkg::udpil_resp_t bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire udpil_pkg::udpil_addr_t araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire udpil_pkg::udpil_resp_t rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Line side
  input wire logic txValid,
  input wire udpil_pkg::udpil_byte_t txData,
  input wire logic txReady,
  input wire logic irq
);
  import udpil_pkg::*;
  // ==========================================================
  // Shadow of mode bits
  logic extReg, fenReg;
  logic [3:0] rdIdxReg;
  wire wrHit = awready && wready && wstrb[0];
  wire isIer = rvalid && rdIdxReg == `UDPIL_IDX_IER;
  wire isEir = rvalid && rdIdxReg == `UDPIL_IDX_EIR && !extReg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      extReg <= 1'b0;
      fenReg <= 1'b0;
      rdIdxReg <= 4'h0;
    end else begin
      if (wrHit && awaddr[5:2] == `UDPIL_IDX_EXT) extReg <= wdata[0];
      if (wrHit && awaddr[5:2] == `UDPIL_IDX_EIR) fenReg <= wdata[`UDPIL_QC_EN];
      if (arvalid && arready) rdIdxReg <= araddr[5:2];
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_reset; $fell(rst) |-> !irq && !bvalid && !rvalid; endproperty
  a_reset: assert property (p_reset) else $error("busy after reset");
  property p_wr_ans; awready && wready |=> bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans; arvalid && arready |=> rvalid ##0 rdata[31:8] == 24'h0; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("bad read answer");
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_wr_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write reply moved");
  property p_tx_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved");
  property p_ier_leg; isIer && !extReg |-> rdata[7:4] == 4'h0; endproperty
  a_ier_leg: assert property (p_ier_leg) else $error("upper enables set");
  property p_ier_ext; isIer && extReg |-> rdata[7:6] == 2'h0 && !rdata[4]; endproperty
  a_ier_ext: assert property (p_ier_ext) else $error("reserved enable set");
  property p_eir_fen; isEir |-> rdata[7:6] == {2{fenReg}} && rdata[5:4] == 2'h0; endproperty
  a_eir_fen: assert property (p_eir_fen) else $error("queue flags wrong");
  property p_eir_idle; isEir && rdata[0] |-> rdata[3:1] == 3'h0; endproperty
  a_eir_idle: assert property (p_eir_idle) else $error("code with no pending");
  property p_eir_to; isEir && !fenReg |-> !rdata[3]; endproperty
  a_eir_to: assert property (p_eir_to) else $error("timeout bit, queues off");
endmodule

bind udpil_top udpil_monitor #(.DEPTH(DEPTH)) mon (
  .mclk(mclk), .rst(rst), .awaddr(awaddr), .awready(awready), .wdata(wdata),
  .wstrb(wstrb), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .txValid(txValid), .txData(txData),
  .txReady(txReady), .irq(irq)
);

// [dv/udpil_line_model.sv]
// Serial far side: receiver deliveries, character ticks and a transmit sink.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module udpil_line_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Receiver side
  output logic rxValid,
  output udpil_pkg::udpil_byte_t rxData,
  output logic rxParityErr,
  output logic rxFrameErr,
  output logic rxBreak,
  output logic charTick,
  // Transmitter side
  input wire logic txValid,
  input wire udpil_pkg::udpil_byte_t txData,
  output logic txReady,
  output logic txIdle
);
  import udpil_pkg::*;
  udpil_byte_t txLog[$];
  udpil_byte_t rxByte = 8'h00, junk = 8'h00;
  logic slow = 1'b0;
  logic [2:0] busyCnt = 3'h0;
  initial {rxValid, rxParityErr, rxFrameErr, rxBreak, charTick, txReady} = 6'h00;
  // Idle data keeps moving so a stale byte is never mistaken for a new one
  assign rxData = rxValid ? rxByte : junk;
  assign txIdle = busyCnt == 3'h0;
  always @(posedge mclk) junk <= junk + 8'h5B;
  // ==========================================================
  // Transmit sink, stalling every other cycle in slow mode
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
      busyCnt <= 3'h0;
    end else begin
      if (txValid && txReady) begin
        txLog.push_back(txData);
        busyCnt <= 3'h4;
      end else if (busyCnt != 3'h0) begin
        busyCnt <= busyCnt - 3'h1;
      end
      txReady <= slow ? ~txReady : 1'b1;
    end
  end
  task automatic sendRx(input udpil_byte_t d, input logic [2:0] e);
    @(posedge mclk);
    rxByte <= d;
    {rxBreak, rxFrameErr, rxParityErr} <= e;
    rxValid <= 1'b1;
    @(posedge mclk);
    rxValid <= 1'b0;
    {rxBreak, rxFrameErr, rxParityErr} <= 3'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      charTick <= 1'b1;
      @(posedge mclk);
      charTick <= 1'b0;
    end
  endtask
endmodule

// [dv/test_uart_data_port_interrupt_logic.sv]
// Directed bench for the data-port and event logic over AXI4-Lite.
// Assumes the line model at the far side and a 100 MHz clock.
`timescale 1ns/1ns
`include "udpil_consts.svh"
module test_uart_data_port_interrupt_logic;
  import udpil_pkg::*;
  localparam udpil_addr_t ADAT = 6'h00, AIER = 6'h04, AEIR = 6'h08, ALSR = 6'h14;
  localparam udpil_addr_t AMSR = 6'h18, AEXT = 6'h20, ABAD = 6'h0C;
  logic mclk = 1'b0, rst = 1'b1;
  udpil_addr_t awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] pinsN = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rxValid, rxPe, rxFe, rxBrk, charTick;
  logic txValid, txReady, txIdle, irq;
  udpil_resp_t bresp, rresp;
  udpil_byte_t rxData, txData;
  int errCount = 0, nTests = 0;
  always #5 mclk = ~mclk;
  udpil_top #(.DEPTH(16)) DUT (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxPe), .rxFrameErr(rxFe),
    .rxBreak(rxBrk), .charTick(charTick), .txValid(txValid), .txData(txData),
    .txReady(txReady), .txIdle(txIdle), .ctsN(pinsN[0]), .dsrN(pinsN[1]),
    .dcdN(pinsN[2]), .riN(pinsN[3]), .irq(irq)
  );
  udpil_line_model line (
    .mclk(mclk), .rst(rst), .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxPe),
    .rxFrameErr(rxFe), .rxBreak(rxBrk), .charTick(charTick), .txValid(txValid),
    .txData(txData), .txReady(txReady), .txIdle(txIdle)
  );
  // ==========================================================
  // Reporting
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      errCount++;
    end
  endtask
  task automatic hang(input int i);
    if (i >= 60) begin
      $display("ERROR wait expected answer seen none");
      errCount++;
      wrapUp();
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    hang(60);
  end
  // ==========================================================
  // Bus cycles: hold each channel until its ready edge
  task automatic wr(input udpil_addr_t a, input udpil_byte_t d, input udpil_resp_t er = 2'h0);
    int i = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      i++;
    end while (!bvalid && i < 60);
    bready <= 1'b0;
    hang(i);
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input udpil_addr_t a, output logic [31:0] d, input udpil_resp_t er = 2'h0);
    int i = 0;
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      i++;
    end while (!rvalid && i < 60);
    rready <= 1'b0;
    hang(i);
    d = rdata;
    chk("rresp", er, rresp);
  endtask
  task automatic rc(input udpil_addr_t a, input udpil_byte_t e, input string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, {24'h0, e}, d);
  endtask
  task automatic chkIrq(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk("irq", e, irq);
  endtask
  task automatic waitTx(input int n);
    int i = 0;
    while (line.txLog.size() < n && i < 60) begin
      repeat (4) @(posedge mclk);
      i++;
    end
    hang(i);
  endtask
  // ==========================================================
  // Tests
  initial begin
    logic [31:0] d;
    int k;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rc(AIER, 8'h00, "ier");
    rc(AEIR, 8'h01, "eir");
    rd(ABAD, d, `UDPIL_RESP_SLVERR);
    chk("bad", 32'h0, d);
    wr(ABAD, 8'h55, `UDPIL_RESP_SLVERR);
    wr(AIER, 8'hFF);
    rc(AIER, 8'h0F, "ier");
    wr(AEXT, 8'h01);
    wr(AIER, 8'hFF);
    rc(AIER, 8'h2F, "ier");
    wr(AEXT, 8'h00);
    rc(AIER, 8'h0F, "ier");
    wr(AIER, 8'h00);
    $display("test enables done");
    line.slow <= 1'b1;
    wr(ADAT, 8'hA5);
    waitTx(1);
    chk("tx", 8'hA5, line.txLog.pop_front());
    wr(AIER, 8'h02);
    chkIrq(1'b1);
    rc(AEIR, 8'h02, "eir");
    rc(AEIR, 8'h01, "eir");
    chkIrq(1'b0);
    wr(AIER, 8'h00);
    line.sendRx(8'h3C, 3'h0);
    rc(AEIR, 8'h01, "eir");
    wr(AIER, 8'h01);
    rc(AEIR, 8'h04, "eir");
    chkIrq(1'b1);
    rc(ADAT, 8'h3C, "rx");
    rc(AEIR, 8'h01, "eir");
    $display("test data ports done");
    // Parity, framing, break, then overrun on a full holding byte
    for (k = 0; k < 4; k++) begin
      wr(AIER, 8'h05);
      line.sendRx(8'(8'h40 + k), k == 3 ? 3'h0 : 3'(1 << k));
      if (k == 3) line.sendRx(8'h7E, 3'h0);
      rc(AEIR, 8'h06, "eir");
      rd(ALSR, d);
      rc(AEIR, 8'h04, "eir");
      rc(ADAT, 8'(8'h40 + k), "rx");
      wr(AIER, 8'h00);
    end
    wr(AIER, 8'h08);
    for (k = 0; k < 4; k++) begin
      pinsN[k] <= 1'b0;
      repeat (4) @(posedge mclk);
      rc(AEIR, k == 3 ? 8'h01 : 8'h00, "eir");
      rd(AMSR, d);
      pinsN[k] <= 1'b1;
      repeat (4) @(posedge mclk);
      rc(AEIR, 8'h00, "eir");
      rd(AMSR, d);
      rc(AEIR, 8'h01, "eir");
    end
    $display("test line and modem done");
    wr(AIER, 8'h00);
    wr(AEIR, 8'hC1);
    rc(AEIR, 8'hC1, "eir");
    for (k = 0; k < 3; k++) wr(ADAT, 8'(8'h61 + k));
    waitTx(3);
    for (k = 0; k < 3; k++) chk("tx", 8'(8'h61 + k), line.txLog.pop_front());
    wr(AIER, 8'h01);
    line.sendRx(8'h11, 3'h0);
    line.sendRx(8'h22, 3'h0);
    line.tick(3);
    rc(AEIR, 8'hC1, "eir");
    line.tick(1);
    rc(AEIR, 8'hCC, "eir");
    rc(ADAT, 8'h11, "rx");
    rc(AEIR, 8'hC1, "eir");
    rc(ADAT, 8'h22, "rx");
    wr(AEIR, 8'h00);
    $display("test queues done");
    wr(AEXT, 8'h01);
    wr(AIER, 8'h00);
    line.sendRx(8'h5A, 3'h0);
    rd(AEIR, d);
    chk("eir", 32'h21, d & 32'h21);
    chkIrq(1'b0);
    wr(AIER, 8'h01);
    chkIrq(1'b1);
    rc(ADAT, 8'h5A, "rx");
    wr(AIER, 8'h20);
    chkIrq(1'b1);
    $display("test extended done");
    wrapUp();
  end
endmodule
